// [hw/fault_record_pkg.sv]
// Constants for the fault record framer
package fault_record_pkg;
  // ------------------------------------------------------------
  // Record geometry
  // ------------------------------------------------------------
  localparam int unsigned REC_LEN     = 147;
  localparam int unsigned HDR_LEN     = 27;
  localparam int unsigned PAGE_LEN    = 20;
  localparam int unsigned PAGE_CNT    = 6;
  localparam int unsigned NVM_LAST_PG = 3;
  localparam logic [7:0]  LEN_FULL    = 8'h93;
  localparam logic [7:0]  LEN_NONE    = 8'h00;
  // ------------------------------------------------------------
  // Header byte numbers
  // ------------------------------------------------------------
  localparam int unsigned B_SOURCE    = 4;
  localparam int unsigned B_TIME      = 5;
  localparam int unsigned B_PEAK      = 11;
  localparam int unsigned B_IOUT1_PK  = 17;
  localparam int unsigned B_VIN_PK    = 19;
  localparam int unsigned B_TEMP      = 21;
  localparam int unsigned B_DIE_TEMP  = 25;
  localparam int unsigned B_PAGE_N    = 27;
  localparam int unsigned B_PAGE_N1   = 47;
  // ------------------------------------------------------------
  // Multiplexer steps
  // ------------------------------------------------------------
  localparam logic [4:0]  STEP_VOUT0  = 5'h00;
  localparam logic [4:0]  STEP_VOUT1  = 5'h01;
  localparam logic [4:0]  STEP_IOUT0  = 5'h02;
  localparam logic [4:0]  STEP_IOUT1  = 5'h03;
  localparam logic [4:0]  STEP_VIN    = 5'h04;
  localparam logic [4:0]  STEP_IIN    = 5'h05;
  localparam logic [4:0]  STEP_TEMP0  = 5'h06;
  localparam logic [4:0]  STEP_TEMP1  = 5'h07;
  localparam logic [4:0]  STEP_DIE    = 5'h08;
  localparam logic [4:0]  STEP_LAST   = 5'h19;
  localparam int unsigned PEAK_CNT    = 5;
  localparam int unsigned MEAS_CNT    = 9;
  // Neutral preface word, value arbitrary
  localparam logic [31:0] PREFACE     = 32'h4641_4c54;
  typedef enum logic [1:0] {RD_IDLE, RD_LEN, RD_DATA} rd_state_t;
endpackage : fault_record_pkg

// [hw/fault_record_framer.sv]
// Fault record capture and block read serializer
//
// Behaviour
// RULE1: Channel 1 peak output current at bytes 17 and 18, upper first.
// RULE2: Peak input voltage at bytes 19 and 20, upper first.
// RULE3: External sensor 0 temperature at 21-22, sensor 1 at 23-24.
// RULE4: Die temperature of the last event at bytes 25 and 26.
// RULE5: Each event page holds one complete multiplexer pass.
// RULE6: On fault, finish the pass through step 25, then freeze everything; peak_q and meas_q keep tracking, and a fault at step 25 freezes after the next pass.
// RULE7: Newest page at bytes 27-46 in the fixed field order.
// RULE8: Previous page starts at byte 47 with the same field order.
// RULE9: Block read gives 147 bytes with a log, length zero without.
// RULE10: After restore from storage pages five and six repeat page four.
// RULE11: Bytes leave in ascending byte order in a single read.
`timescale 1ns/100ps
module fault_record_framer #(
  parameter logic [31:0] PREFACE_WORD = fault_record_pkg::PREFACE
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        sample_valid,
  input  wire logic [4:0]  sample_step,
  input  wire logic [15:0] sample_data,
  input  wire logic [7:0]  status_vout0,
  input  wire logic [7:0]  status_vout1,
  input  wire logic [15:0] status_word0,
  input  wire logic [15:0] status_word1,
  input  wire logic [7:0]  status_mfr0,
  input  wire logic [7:0]  status_mfr1,
  input  wire logic        fault,
  input  wire logic [7:0]  fault_source,
  input  wire logic [47:0] real_time,
  input  wire logic        clear_peak_values,
  input  wire logic        log_clear,
  input  wire logic        nvm_restored,
  input  wire logic        fault_record_read,
  input  wire logic        out_ready,
  output logic             out_valid,
  output logic [7:0]       out_data,
  output logic             out_last,
  output logic             log_valid
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic signed [63:0] l11_val(input logic [15:0] v);
    logic signed [63:0] m;
    logic signed [5:0]  e;
    m = 64'(signed'(v[10:0]));
    e = 6'(signed'(v[15:11]));
    return m <<< (e + 6'sd16);
  endfunction : l11_val

  localparam int unsigned PN = fault_record_pkg::PAGE_CNT;
  localparam int unsigned PL = fault_record_pkg::PAGE_LEN;
  localparam int unsigned PK = fault_record_pkg::PEAK_CNT;
  localparam int unsigned MC = fault_record_pkg::MEAS_CNT;

  logic [15:0] meas_q [MC];
  logic [15:0] meas_d [MC];
  logic [15:0] peak_q [PK];
  logic [15:0] peak_d [PK];
  logic [15:0] pksnap_q [PK];
  logic [15:0] pksnap_d [PK];
  logic [15:0] temp_q [3];
  logic [15:0] temp_d [3];
  logic [7:0]  page_q [PN][PL];
  logic [7:0]  page_d [PN][PL];
  logic [7:0]  src_q, src_d;
  logic [47:0] time_q, time_d;
  logic        pend_q, pend_d;
  logic        valid_q, valid_d;
  logic        pass_end;
  logic [7:0]  newpg [PL];

  assign pass_end = sample_valid && sample_step == fault_record_pkg::STEP_LAST;
  assign log_valid = valid_q;

  // ------------------------------------------------------------
  // Pass collection and peak tracking
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < MC; i++) begin
      meas_d[i] = meas_q[i];
      if (sample_valid && sample_step == 5'(i)) begin
        meas_d[i] = sample_data;
      end
    end
  end

  genvar g;
  for (g = 0; g < PK; g++) begin : g_peak
    logic hit;
    logic higher;
    assign hit = sample_valid && sample_step == 5'(g);
    assign higher = (g < 2) ? sample_data > peak_q[g]
                            : l11_val(sample_data) > l11_val(peak_q[g]);
    always_comb begin
      peak_d[g] = peak_q[g];
      if (clear_peak_values) begin
        peak_d[g] = 16'h0000;
      end else if (hit && higher) begin // RULE1 RULE2
        peak_d[g] = sample_data;
      end
    end
    always_ff @(posedge clock) begin
      if (srst) begin
        peak_q[g] <= 16'h0000;
      end else begin
        peak_q[g] <= peak_d[g];
      end
    end
  end

  // ------------------------------------------------------------
  // Page assembly, ring of pages and freeze
  // ------------------------------------------------------------
  always_comb begin
    // RULE7: newest page field order
    newpg[0]  = meas_q[0][15:8];
    newpg[1]  = meas_q[0][7:0];
    newpg[2]  = meas_q[1][15:8];
    newpg[3]  = meas_q[1][7:0];
    newpg[4]  = meas_q[2][15:8];
    newpg[5]  = meas_q[2][7:0];
    newpg[6]  = meas_q[3][15:8];
    newpg[7]  = meas_q[3][7:0];
    newpg[8]  = meas_q[4][15:8];
    newpg[9]  = meas_q[4][7:0];
    newpg[10] = meas_q[5][15:8];
    newpg[11] = meas_q[5][7:0];
    newpg[12] = status_vout0;
    newpg[13] = status_vout1;
    newpg[14] = status_word0[15:8];
    newpg[15] = status_word0[7:0];
    newpg[16] = status_word1[15:8];
    newpg[17] = status_word1[7:0];
    newpg[18] = status_mfr0;
    newpg[19] = status_mfr1;
  end

  always_comb begin
    page_d   = page_q;
    pksnap_d = pksnap_q;
    temp_d   = temp_q;
    src_d    = src_q;
    time_d   = time_q;
    pend_d   = pend_q;
    valid_d  = valid_q;
    if (fault && !pend_q && !valid_q) begin
      pend_d = 1'b1;
      src_d  = fault_source;
      time_d = real_time;
    end
    if (pass_end && !valid_q) begin
      // Whole pass only, so a page never mixes two passes
      for (int p = PN - 1; p > 0; p--) begin
        page_d[p] = page_q[p-1]; // RULE5 RULE8
      end
      page_d[0] = newpg;
      if (pend_q) begin // RULE6
        valid_d  = 1'b1;
        pend_d   = 1'b0;
        pksnap_d = peak_q;
        for (int t = 0; t < 3; t++) begin
          temp_d[t] = meas_q[6+t]; // RULE3 RULE4
        end
      end
    end
    if (log_clear && !(pass_end && pend_q)) begin
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pend_q  <= 1'b0;
      valid_q <= 1'b0;
      src_q   <= 8'h00;
      time_q  <= 48'h0;
      for (int i = 0; i < MC; i++) meas_q[i] <= 16'h0000;
      for (int i = 0; i < PK; i++) pksnap_q[i] <= 16'h0000;
      for (int i = 0; i < 3; i++) temp_q[i] <= 16'h0000;
      for (int p = 0; p < PN; p++) begin
        for (int b = 0; b < PL; b++) page_q[p][b] <= 8'h00;
      end
    end else begin
      pend_q   <= pend_d;
      valid_q  <= valid_d;
      src_q    <= src_d;
      time_q   <= time_d;
      meas_q   <= meas_d;
      pksnap_q <= pksnap_d;
      temp_q   <= temp_d;
      page_q   <= page_d;
    end
  end

  // ------------------------------------------------------------
  // Record byte lookup
  // ------------------------------------------------------------
  function automatic logic [7:0] rec_byte(input logic [7:0] n);
    logic [7:0] off;
    logic [2:0] pg;
    logic [4:0] bi;
    off = n - 8'(fault_record_pkg::HDR_LEN);
    pg  = 3'(off / 8'(PL));
    bi  = 5'(off % 8'(PL));
    if (nvm_restored && pg > 3'(fault_record_pkg::NVM_LAST_PG)) begin
      pg = 3'(fault_record_pkg::NVM_LAST_PG); // RULE10
    end
    if (n < 8'(fault_record_pkg::B_SOURCE)) begin
      return PREFACE_WORD[8'(31) - n*8 -: 8];
    end else if (n == 8'(fault_record_pkg::B_SOURCE)) begin
      return src_q;
    end else if (n < 8'(fault_record_pkg::B_PEAK)) begin
      return time_q[(n - 8'(fault_record_pkg::B_TIME))*8 +: 8];
    end else if (n < 8'(fault_record_pkg::B_TEMP)) begin
      off = n - 8'(fault_record_pkg::B_PEAK); // RULE1 RULE2
      return off[0] ? pksnap_q[off[3:1]][7:0] : pksnap_q[off[3:1]][15:8];
    end else if (n < 8'(fault_record_pkg::B_PAGE_N)) begin
      off = n - 8'(fault_record_pkg::B_TEMP); // RULE3 RULE4
      return off[0] ? temp_q[off[2:1]][7:0] : temp_q[off[2:1]][15:8];
    end
    return page_q[pg][bi]; // RULE7 RULE8
  endfunction : rec_byte

  // ------------------------------------------------------------
  // Block read serializer
  // ------------------------------------------------------------
  fault_record_pkg::rd_state_t st_q, st_d;
  logic [7:0] idx_q, idx_d;
  logic [7:0] dat_q, dat_d;
  localparam logic [7:0] LAST_IDX = 8'(fault_record_pkg::REC_LEN - 1);

  always_comb begin
    st_d  = st_q;
    idx_d = idx_q;
    dat_d = dat_q;
    case (st_q)
      fault_record_pkg::RD_IDLE: begin
        if (fault_record_read) begin
          st_d  = fault_record_pkg::RD_LEN;
          dat_d = valid_q ? fault_record_pkg::LEN_FULL
                          : fault_record_pkg::LEN_NONE; // RULE9
        end
      end
      fault_record_pkg::RD_LEN: begin
        if (out_ready) begin
          st_d  = valid_q ? fault_record_pkg::RD_DATA
                          : fault_record_pkg::RD_IDLE;
          idx_d = 8'h00;
          dat_d = rec_byte(8'h00);
        end
      end
      fault_record_pkg::RD_DATA: begin
        if (out_ready) begin
          if (idx_q == LAST_IDX) begin
            st_d = fault_record_pkg::RD_IDLE;
          end else begin
            idx_d = idx_q + 8'h01; // RULE11
            dat_d = rec_byte(idx_q + 8'h01);
          end
        end
      end
      default: st_d = fault_record_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q  <= fault_record_pkg::RD_IDLE;
      idx_q <= 8'h00;
      dat_q <= 8'h00;
    end else begin
      st_q  <= st_d;
      idx_q <= idx_d;
      dat_q <= dat_d;
    end
  end

  assign out_valid = st_q != fault_record_pkg::RD_IDLE;
  assign out_data  = dat_q;
  assign out_last  = (st_q == fault_record_pkg::RD_LEN && !valid_q) ||
                     (st_q == fault_record_pkg::RD_DATA && idx_q == LAST_IDX);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_pend_end;
    pend_q && !valid_q && pass_end;
  endsequence
  sequence s_len_beat;
    st_q == fault_record_pkg::RD_LEN && out_ready;
  endsequence

  AST_FREEZE: assert property (@(posedge clock) disable iff (srst) // RULE6
    s_pend_end |=> valid_q && pksnap_q[4] == $past(peak_q[4]))
    else $error("log not frozen at pass end");
  AST_NO_EARLY: assert property (@(posedge clock) disable iff (srst) // RULE5
    $rose(valid_q) |-> $past(pass_end) && $past(pend_q))
    else $error("log frozen mid pass");
  AST_LEN: assert property (@(posedge clock) disable iff (srst) // RULE9
    st_q == fault_record_pkg::RD_LEN |->
    out_data == (valid_q ? 8'h93 : 8'h00) && out_last == !valid_q)
    else $error("bad block length");
  AST_ORDER: assert property (@(posedge clock) disable iff (srst) // RULE11
    st_q == fault_record_pkg::RD_DATA && out_ready && !out_last
    |=> idx_q == $past(idx_q) + 8'h01)
    else $error("bytes out of order");
  AST_FIRST: assert property (@(posedge clock) disable iff (srst) // RULE11
    s_len_beat and valid_q |=> st_q == fault_record_pkg::RD_DATA
    && idx_q == 8'h00 && out_data == PREFACE_WORD[31:24])
    else $error("record did not start at byte 0");
  AST_IOUT1: assert property (@(posedge clock) disable iff (srst) // RULE1
    st_q == fault_record_pkg::RD_DATA && idx_q == 8'd18 &&
    $past(idx_q) == 8'd17 |->
    out_data == pksnap_q[3][7:0] && $past(out_data) == pksnap_q[3][15:8])
    else $error("peak current misplaced");
  AST_VIN: assert property (@(posedge clock) disable iff (srst) // RULE2
    st_q == fault_record_pkg::RD_DATA && idx_q == 8'd19 |->
    out_data == pksnap_q[4][15:8])
    else $error("peak input voltage misplaced");
  AST_TEMP: assert property (@(posedge clock) disable iff (srst) // RULE3
    st_q == fault_record_pkg::RD_DATA && idx_q == 8'd23 |->
    out_data == temp_q[1][15:8])
    else $error("sensor 1 misplaced");
  AST_DIE: assert property (@(posedge clock) disable iff (srst) // RULE4
    st_q == fault_record_pkg::RD_DATA && idx_q == 8'd26 |->
    out_data == temp_q[2][7:0])
    else $error("die temperature misplaced");
  AST_PAGE: assert property (@(posedge clock) disable iff (srst) // RULE7
    st_q == fault_record_pkg::RD_DATA && idx_q == 8'd42 |->
    out_data == page_q[0][15])
    else $error("status word misplaced");
  AST_PREV: assert property (@(posedge clock) disable iff (srst) // RULE8
    pass_end && !valid_q |=> page_q[1][0] == $past(page_q[0][0]))
    else $error("previous page not kept");
  AST_NVM: assert property (@(posedge clock) disable iff (srst) // RULE10
    st_q == fault_record_pkg::RD_DATA && nvm_restored && idx_q >= 8'd107
    |-> out_data == page_q[3][5'((idx_q - 8'd27) % 8'd20)])
    else $error("restored pages not repeated");
endmodule : fault_record_framer

// [dv/host_reader.sv]
// Block read host model that collects the streamed record
`timescale 1ns/100ps
module host_reader (
  input  wire logic       clock,
  input  wire logic       stall_en,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output logic            out_ready
);
  logic [7:0] got[$];
  logic       done;
  int         seed = 18;
  initial begin
    out_ready = 1'b1;
    done = 1'b0;
  end
  task automatic restart();
    got.delete();
    done = 1'b0;
  endtask : restart
  // Extra bytes after the last are kept so the bench can see them
  always @(posedge clock) begin
    if (out_valid && out_ready) begin
      got.push_back(out_data);
      if (out_last) done = 1'b1;
    end
    #2 out_ready <= !stall_en || (($random(seed) & 3) != 0);
  end
endmodule : host_reader

// [dv/fault_record_framer_tb.sv]
// Self-checking bench for the fault record framer
`timescale 1ns/100ps
module fault_record_framer_tb;
  logic        clock, srst, sample_valid, fault, log_clear, stall_en;
  logic        clear_peak_values, nvm_restored, fault_record_read;
  logic        out_ready, out_valid, out_last, log_valid, frozen, pend;
  logic [4:0]  sample_step;
  logic [15:0] sample_data, status_word0, status_word1;
  logic [7:0]  status_vout0, status_vout1, status_mfr0, status_mfr1;
  logic [7:0]  fault_source, out_data, src;
  logic [47:0] real_time, tim;
  logic [15:0] cur[9];
  logic [15:0] peak[5];
  logic [7:0]  pages[6][20];
  logic [7:0]  hdr[27];
  int          seed = 18;
  int          err_count = 0;
  int          num_checks = 0;

  fault_record_framer fault_record_framer_inst (.clock, .srst,
    .sample_valid, .sample_step, .sample_data, .status_vout0,
    .status_vout1, .status_word0, .status_word1, .status_mfr0,
    .status_mfr1, .fault, .fault_source, .real_time, .clear_peak_values,
    .log_clear, .nvm_restored, .fault_record_read, .out_ready,
    .out_valid, .out_data, .out_last, .log_valid);
  host_reader host_reader_inst (.clock, .stall_en, .out_valid,
    .out_data, .out_last, .out_ready);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Generous bound, a full run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    test_done();
  end

  // ----------------------------------------
  // Checks and expectations
  // ----------------------------------------
  task automatic check8(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : check8
  task automatic check1(string nm, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask : check1
  function automatic real l11(logic [15:0] v);
    return $itor($signed(v[10:0])) * 2.0 ** $signed(v[15:11]);
  endfunction : l11
  // Output voltages compare unsigned, the rest by decoded value
  function automatic logic [15:0] upd(int s, logic [15:0] p,
                                      logic [15:0] v);
    if (s < 2) return (v > p) ? v : p;
    return (l11(v) > l11(p)) ? v : p;
  endfunction : upd
  function automatic logic [7:0] rec(int i, logic nvm);
    int k;
    if (i < 27) return hdr[i];
    k = (i - 27) / 20;
    if (nvm && k > 3) k = 3;
    return pages[k][(i - 27) % 20];
  endfunction : rec

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic pass(int fault_at);
    logic [7:0] p[20];
    for (int s = 0; s < 26; s++) begin
      sample_valid = 1'b1;
      sample_step = s[4:0];
      sample_data = 16'($random(seed));
      fault = (s == fault_at);
      fault_source = 8'($random(seed));
      real_time = 48'({$random(seed), $random(seed)});
      {status_vout0, status_vout1} = 16'($random(seed));
      {status_word0, status_word1} = $random(seed);
      {status_mfr0, status_mfr1} = 16'($random(seed));
      if (s < 9) cur[s] = sample_data;
      if (s < 5 && !frozen) peak[s] = upd(s, peak[s], sample_data);
      if (fault && !frozen && !pend) begin
        pend = 1'b1;
        src = fault_source;
        tim = real_time;
      end
      @(posedge clock);
      #2;
      if (s == 25 && !frozen) begin
        for (int i = 0; i < 6; i++) {p[2*i], p[2*i+1]} = cur[i];
        {p[12], p[13]} = {status_vout0, status_vout1};
        {p[14], p[15], p[16], p[17]} = {status_word0, status_word1};
        {p[18], p[19]} = {status_mfr0, status_mfr1};
        for (int k = 5; k > 0; k--) pages[k] = pages[k-1];
        pages[0] = p;
        if (pend) begin
          frozen = 1'b1;
          {hdr[0], hdr[1], hdr[2], hdr[3]} = fault_record_pkg::PREFACE;
          hdr[4] = src;
          for (int i = 0; i < 6; i++) hdr[5+i] = tim[8*i +: 8];
          for (int i = 0; i < 5; i++) {hdr[11+2*i], hdr[12+2*i]} = peak[i];
          for (int i = 0; i < 3; i++) {hdr[21+2*i], hdr[22+2*i]} = cur[6+i];
        end
      end
      check1("log_valid", frozen, log_valid);
    end
    sample_valid = 1'b0;
    fault = 1'b0;
  endtask : pass
  task automatic read(logic full, logic nvm);
    int n;
    nvm_restored = nvm;
    stall_en = 1'($random(seed));
    host_reader_inst.restart();
    fault_record_read = 1'b1;
    for (n = 0; n < 2000 && !host_reader_inst.done; n++) begin
      @(posedge clock);
      #2;
      fault_record_read = (n == 5);
    end
    fault_record_read = 1'b0;
    check1("idle after read", 1'b0, out_valid);
    check8("length", full ? 8'h93 : 8'h00, host_reader_inst.got[0]);
    check8("count", full ? 8'h94 : 8'h01,
           8'(host_reader_inst.got.size()));
    if (full) begin
      cmp(0, 16, nvm);
      cmp(17, 18, nvm);
      cmp(19, 20, nvm);
      cmp(21, 24, nvm);
      cmp(25, 26, nvm);
      cmp(27, 46, nvm);
      cmp(47, 106, nvm);
      cmp(107, 146, nvm);
    end
  endtask : read
  task automatic cmp(int lo, int hi, logic nvm);
    for (int i = lo; i <= hi; i++)
      check8($sformatf("byte %0d", i), rec(i, nvm),
             host_reader_inst.got[i + 1]);
  endtask : cmp
  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    {srst, sample_valid, fault, log_clear, stall_en} = 5'h10;
    {clear_peak_values, nvm_restored, fault_record_read} = 3'h0;
    {sample_step, sample_data, fault_source, real_time} = '0;
    {status_vout0, status_vout1, status_word0} = '0;
    {status_word1, status_mfr0, status_mfr1} = '0;
    {frozen, pend} = 2'h0;
    peak = '{default: '0};
    pages = '{default: '{default: '0}};
    repeat (20) @(posedge clock);
    #2 srst = 1'b0;
    read(1'b0, 1'b0);
    repeat (3) pass(-1);
    clear_peak_values = 1'b1;
    @(posedge clock);
    #2 clear_peak_values = 1'b0;
    peak = '{default: '0};
    repeat (3) pass(-1);
    pass(($random(seed) & 15) + 9);
    pass(3);
    read(1'b1, 1'b0);
    read(1'b1, 1'b1);
    log_clear = 1'b1;
    @(posedge clock);
    #2 log_clear = 1'b0;
    check1("log_valid", 1'b0, log_valid);
    read(1'b0, 1'b0);
    test_done();
  end
endmodule : fault_record_framer_tb
